// ==== ticu_defines.vh ====
`ifndef TICU_DEFINES_VH
`define TICU_DEFINES_VH
// printed offsets 0x92 and 0x93 are not multiples of four: kept as indices
`define TICU_IDX_ENFLAGS 8'h92
`define TICU_IDX_EDGESEL 8'h93
`define TICU_IDX_FILTER 8'h94
`define TICU_IDX_TIMER 8'ha0
`define TICU_IDX_RESULT0 8'ha1
`define TICU_IDX_RESULT1 8'ha2
`define TICU_IDX_MODE 8'ha3
`define TICU_RST_BYTE 8'h00
`define TICU_BIT_EN0 4
`define TICU_BIT_EN1 5
`define TICU_BIT_FLAG0 0
`define TICU_BIT_FLAG1 1
`define TICU_BIT_FEN0 4
`define TICU_BIT_FEN1 5
`define TICU_BIT_CMP_RELOAD 0
`define TICU_BIT_AUTO_RELOAD 1
`define TICU_BIT_CLR_ON_CAP 2
`define TICU_BIT_CAP_IRQ_EN 3
`define TICU_BIT_GLB_IRQ_EN 4
`define TICU_BIT_TIMER_RUN 5
`define TICU_EDGE_FALL 2'b00
`define TICU_EDGE_RISE 2'b01
`define TICU_EDGE_BOTH 2'b10
`define TICU_FILTER_CLKS 4
`endif

// ==== ticu_filter.v ====
`timescale 1ns/1ps
`include "ticu_defines.vh"
module ticu_filter #(
  parameter MIN_CLKS = `TICU_FILTER_CLKS
) (
  // clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // control
  input wire filter_enable_in,
  input wire raw_in,
  // filtered level
  output reg level_out
);
  reg [2:0] stable_cnt_reg;
  reg last_reg;
  // a new level passes only after MIN_CLKS identical samples
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      stable_cnt_reg <= 3'h0;
      last_reg <= 1'b0;
      level_out <= 1'b0;
    end else begin
      last_reg <= raw_in;
      if (raw_in != last_reg) begin
        stable_cnt_reg <= 3'h1;
      end else if (stable_cnt_reg < MIN_CLKS[2:0]) begin
        stable_cnt_reg <= stable_cnt_reg + 3'h1;
      end
      if (!filter_enable_in) begin
        level_out <= raw_in;
      end else if (raw_in == last_reg && stable_cnt_reg >= MIN_CLKS[2:0] - 3'h1) begin
        level_out <= raw_in; // [RL2]
      end
    end
  end
endmodule

// ==== ticu_edge.v ====
`timescale 1ns/1ps
`include "ticu_defines.vh"
module ticu_edge (
  // clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // control
  input wire [1:0] edge_select_in,
  input wire level_in,
  // one-cycle event
  output wire edge_out
);
  reg prev_reg;
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_in;
    end
  end
  wire rise = level_in & ~prev_reg;
  wire fall = ~level_in & prev_reg;
  // code 11 is reserved and captures nothing
  assign edge_out = (edge_select_in == `TICU_EDGE_FALL) ? fall :
                    (edge_select_in == `TICU_EDGE_RISE) ? rise :
                    (edge_select_in == `TICU_EDGE_BOTH) ? (rise | fall) : 1'b0; // [RL3] [RL5]
endmodule

// ==== ticu_top.v ====
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "ticu_defines.vh"
// Contract
// [RL1] capture only when compare/reload select and auto-reload enable are both clear
// [RL2] per-channel filter enable bits 5/4 reject pulses shorter than 4 clocks
// [RL3] edge select per channel: 00 falling, 01 rising, 10 both, 11 reserved
// [RL4] channel reacts only while its enable bit (5 ch1, 4 ch0) is set
// [RL5] each channel has its own edge detector sharing one 16-bit timer
// [RL6] qualifying edge copies timer high and low bytes into channel result
// [RL7] qualifying edge on channel n sets flag bit n
// [RL8] interrupt requested only while capture and global irq enables are set
// [RL9] software reads flags to find channel and clears them itself
// [RL10] with auto-clear set, timer resets to zero right after capture
// [RL11] hardware flag set wins over a same-cycle software clear
module ticu_top (
  // clock and reset
  input wire clk_in,
  input wire sys_rst_in,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // capture pins
  input wire capture_input_0_in,
  input wire capture_input_1_in,
  // status
  output wire [15:0] timer_value_out,
  output wire capture_irq_out
);
  reg [7:0] enflags_reg;
  reg [7:0] edgesel_reg;
  reg [7:0] filter_reg;
  reg [5:0] mode_reg;
  reg [15:0] timer_reg;
  reg [15:0] result0_reg;
  reg [15:0] result1_reg;
  reg ph_write_reg;
  reg [7:0] ph_idx_reg;

  function [7:0] addr_to_idx;
    input [31:0] a;
    begin
      addr_to_idx = a[9:2];
    end
  endfunction

  // bus: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire addr_phase = hsel & hready & htrans[1];

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ph_write_reg <= 1'b0;
      ph_idx_reg <= 8'h00;
    end else begin
      ph_write_reg <= addr_phase & hwrite;
      ph_idx_reg <= addr_to_idx(haddr);
    end
  end

  wire wr_en = ph_write_reg;
  wire wr_flags = wr_en && ph_idx_reg == `TICU_IDX_ENFLAGS;

  // capture path
  wire lvl0;
  wire lvl1;
  wire edge0;
  wire edge1;
  ticu_filter #(.MIN_CLKS(`TICU_FILTER_CLKS)) u_filt0 (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .filter_enable_in(filter_reg[`TICU_BIT_FEN0]),
    .raw_in(capture_input_0_in),
    .level_out(lvl0)
  );
  ticu_filter #(.MIN_CLKS(`TICU_FILTER_CLKS)) u_filt1 (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .filter_enable_in(filter_reg[`TICU_BIT_FEN1]),
    .raw_in(capture_input_1_in),
    .level_out(lvl1)
  );
  ticu_edge u_edge0 (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .edge_select_in(edgesel_reg[1:0]),
    .level_in(lvl0),
    .edge_out(edge0)
  );
  ticu_edge u_edge1 (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .edge_select_in(edgesel_reg[3:2]),
    .level_in(lvl1),
    .edge_out(edge1)
  );

  wire capture_mode = ~mode_reg[`TICU_BIT_CMP_RELOAD] & ~mode_reg[`TICU_BIT_AUTO_RELOAD]; // [RL1]
  wire cap0 = capture_mode & enflags_reg[`TICU_BIT_EN0] & edge0; // [RL4]
  wire cap1 = capture_mode & enflags_reg[`TICU_BIT_EN1] & edge1; // [RL4]

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      result0_reg <= 16'h0000;
      result1_reg <= 16'h0000;
    end else begin
      if (cap0) begin
        result0_reg <= timer_reg; // [RL6]
      end
      if (cap1) begin
        result1_reg <= timer_reg; // [RL6]
      end
    end
  end

  // timer: free running while enabled; auto-clear follows the captured value
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      timer_reg <= 16'h0000;
    end else if ((cap0 | cap1) & mode_reg[`TICU_BIT_CLR_ON_CAP]) begin
      timer_reg <= 16'h0000; // [RL10]
    end else if (wr_en && ph_idx_reg == `TICU_IDX_TIMER) begin
      timer_reg <= hwdata[15:0];
    end else if (mode_reg[`TICU_BIT_TIMER_RUN]) begin
      timer_reg <= timer_reg + 16'h0001;
    end
  end

  // flags: software writes zero to clear; a capture in the same cycle wins
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      enflags_reg <= `TICU_RST_BYTE;
      edgesel_reg <= `TICU_RST_BYTE;
      filter_reg <= `TICU_RST_BYTE;
      mode_reg <= 6'h00;
    end else begin
      if (wr_flags) begin
        enflags_reg[5:4] <= hwdata[5:4];
        enflags_reg[`TICU_BIT_FLAG0] <= hwdata[0] | cap0; // [RL11] [RL9]
        enflags_reg[`TICU_BIT_FLAG1] <= hwdata[1] | cap1; // [RL11]
      end else begin
        if (cap0) begin
          enflags_reg[`TICU_BIT_FLAG0] <= 1'b1; // [RL7]
        end
        if (cap1) begin
          enflags_reg[`TICU_BIT_FLAG1] <= 1'b1; // [RL7]
        end
      end
      if (wr_en && ph_idx_reg == `TICU_IDX_EDGESEL) begin
        edgesel_reg[3:0] <= hwdata[3:0];
      end
      if (wr_en && ph_idx_reg == `TICU_IDX_FILTER) begin
        filter_reg[5:4] <= hwdata[5:4];
      end
      if (wr_en && ph_idx_reg == `TICU_IDX_MODE) begin
        mode_reg <= hwdata[5:0];
      end
    end
  end

  // shared interrupt line for both channels
  assign capture_irq_out = mode_reg[`TICU_BIT_CAP_IRQ_EN] & mode_reg[`TICU_BIT_GLB_IRQ_EN] &
                           (enflags_reg[`TICU_BIT_FLAG0] | enflags_reg[`TICU_BIT_FLAG1]); // [RL8]
  assign timer_value_out = timer_reg;

  // read data registered at the end of the address phase
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase & ~hwrite) begin
      case (addr_to_idx(haddr))
        `TICU_IDX_ENFLAGS: hrdata <= {24'h000000, enflags_reg};
        `TICU_IDX_EDGESEL: hrdata <= {24'h000000, edgesel_reg};
        `TICU_IDX_FILTER: hrdata <= {24'h000000, filter_reg};
        `TICU_IDX_TIMER: hrdata <= {16'h0000, timer_reg};
        `TICU_IDX_RESULT0: hrdata <= {16'h0000, result0_reg};
        `TICU_IDX_RESULT1: hrdata <= {16'h0000, result1_reg};
        `TICU_IDX_MODE: hrdata <= {26'h0000000, mode_reg};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ==== ticu_pins.sv ====
`timescale 1ns/1ps
// far-side signal source: a driven input, so each pin keeps its level between edges
module ticu_pins (
  input wire clk_in,
  output logic [1:0] pin_out
);
  initial pin_out = 2'h0;
  task automatic step(input int ch);
    pin_out <= pin_out ^ (2'h1 << ch);
    @(posedge clk_in);
  endtask
  // len sets how long the level stands: short for glitches, long for real edges
  task automatic pulse(input int ch, input int len);
    step(ch);
    repeat (len - 1) @(posedge clk_in);
    step(ch);
  endtask
endmodule

// ==== ticu_props.sv ====
`timescale 1ns/1ps
module ticu_props (
  input wire clk_in,
  input wire sys_rst_in,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire capture_input_0_in,
  input wire capture_input_1_in,
  input wire [15:0] timer_value_out,
  input wire capture_irq_out
);
  logic wr_d;
  logic [4:0] quiet;
  logic [1:0] pin_d;
  wire acc = hsel && hready && htrans[1];
  // a pin change or a write restarts the count that bounds irq and clear latency
  always @(posedge clk_in) begin
    pin_d <= {capture_input_1_in, capture_input_0_in};
    wr_d <= !sys_rst_in && acc && hwrite;
    if (sys_rst_in) quiet <= 5'h1f;
    else if (wr_d || pin_d != {capture_input_1_in, capture_input_0_in}) quiet <= 5'h0;
    else if (quiet != 5'h1f) quiet <= quiet + 5'h1;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bad response");
  property p_hold; !$past(acc && !hwrite) |-> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_unmap; acc && !hwrite && haddr == 32'h254 |=> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rise; $rose(capture_irq_out) |-> quiet < 5'hc; endproperty
  a_rise: assert property (p_rise) else $error("irq without cause");
  property p_fall; $fell(capture_irq_out) |-> $past(wr_d); endproperty
  a_fall: assert property (p_fall) else $error("irq dropped by hardware");
  property p_jump; !$stable(timer_value_out) && timer_value_out != $past(timer_value_out) + 16'h1
    && timer_value_out != 16'h0 |-> $past(wr_d); endproperty
  a_jump: assert property (p_jump) else $error("timer jumped");
  property p_clr0; timer_value_out == 16'h0 && $past(timer_value_out) != 16'h0
    && $past(timer_value_out) != 16'hffff && !$past(wr_d) |-> quiet < 5'hc; endproperty
  a_clr0: assert property (p_clr0) else $error("timer cleared without capture");
  property p_rst; $fell(sys_rst_in) |-> timer_value_out == 16'h0 && !capture_irq_out; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "ticu_defines.vh"
module testbench;
  logic clk_in = 1'h0;
  logic sys_rst_in = 1'h1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [1:0] htrans = 2'h0;
  logic [1:0] pins;
  logic hwrite = 1'h0;
  logic hrdy;
  logic irq;
  logic [15:0] tmr;
  int mismatches = 0;
  int n_tests = 0;
  always #2.5 clk_in = ~clk_in;
  ticu_pins u_pins (.clk_in(clk_in), .pin_out(pins));
  ticu_top u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
    .hresp(), .capture_input_0_in(pins[0]), .capture_input_1_in(pins[1]), .timer_value_out(tmr),
    .capture_irq_out(irq));
  task automatic complete_run;
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic edge_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hrdy !== 1'h1 && n < 64);
    if (hrdy !== 1'h1) begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic xfer(input logic [7:0] idx, input logic w, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    edge_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(idx, 1'h1, d);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    xfer(idx, 1'h0, 32'h0);
    chk(rd, exp);
  endtask
  // capture path needs at most about eight cycles with the filter on
  task automatic settle;
    repeat (10) @(posedge clk_in);
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    for (int i = 0; i < 4; i++) rc(8'h92 + i[7:0], 32'h0);
    rc(`TICU_IDX_MODE, 32'h0);
    wr(8'h95, 32'hff);
    rc(8'h95, 32'h0);
    wr(`TICU_IDX_TIMER, 32'h1234);
    // the write lands at the data-phase edge; look one edge later
    @(posedge clk_in);
    chk({16'h0, tmr}, 32'h1234);
    wr(`TICU_IDX_EDGESEL, 32'h1);
    wr(`TICU_IDX_ENFLAGS, 32'h10);
    u_pins.pulse(0, 2);
    settle();
    rc(`TICU_IDX_RESULT0, 32'h1234);
    rc(`TICU_IDX_ENFLAGS, 32'h11);
    rc(`TICU_IDX_RESULT1, 32'h0);
    wr(`TICU_IDX_ENFLAGS, 32'h20);
    for (int e = 0; e < 3; e++) begin
      wr(`TICU_IDX_EDGESEL, {28'h0, e[1:0], 2'h2});
      for (int l = 1; l >= 0; l--) begin
        u_pins.step(1);
        u_pins.pulse(0, 2);
        settle();
        rc(`TICU_IDX_ENFLAGS, {30'h8, (l == 1) ? e != 0 : e != 1, 1'h0});
        wr(`TICU_IDX_ENFLAGS, 32'h20);
      end
    end
    wr(`TICU_IDX_FILTER, 32'h10);
    wr(`TICU_IDX_ENFLAGS, 32'h10);
    wr(`TICU_IDX_EDGESEL, 32'h2);
    u_pins.pulse(0, 2);
    settle();
    rc(`TICU_IDX_ENFLAGS, 32'h10);
    u_pins.pulse(0, 6);
    settle();
    rc(`TICU_IDX_ENFLAGS, 32'h11);
    wr(`TICU_IDX_MODE, 32'h08);
    @(posedge clk_in);
    chk(irq, 32'h0);
    wr(`TICU_IDX_MODE, 32'h18);
    @(posedge clk_in);
    chk(irq, 32'h1);
    wr(`TICU_IDX_ENFLAGS, 32'h10);
    @(posedge clk_in);
    chk(irq, 32'h0);
    wr(`TICU_IDX_MODE, 32'h24);
    repeat (40) @(posedge clk_in);
    u_pins.pulse(0, 6);
    settle();
    xfer(`TICU_IDX_TIMER, 1'h0, 32'h0);
    chk(rd >> 5, 32'h0);
    for (int m = 1; m < 3; m++) begin
      wr(`TICU_IDX_ENFLAGS, 32'h10);
      wr(`TICU_IDX_MODE, m);
      u_pins.pulse(0, 6);
      settle();
      rc(`TICU_IDX_ENFLAGS, 32'h10);
    end
    complete_run();
  end
endmodule
bind ticu_top ticu_props u_props (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .capture_input_0_in(capture_input_0_in), .capture_input_1_in(capture_input_1_in),
  .timer_value_out(timer_value_out), .capture_irq_out(capture_irq_out));
